// file: hw/mtlb_pkg.sv
// Package: constants, types and helpers for the TLB translation block
// How it works
// - Writing the process remap id switches context; TLB contents stay valid.
// - The next two fetches still use the old remap id, then it applies.
// - One unified TLB from one table set serves fetches and data accesses.
// - Main TLB is two-way set-associative, 32 sets, 64 entries total.
// - Eight fully associative lockdown entries hold locked translations.
// - Sections 1MB, large pages 64KB, small pages 4KB, tiny pages 1KB.
// - Large and small pages have per-quarter permissions; others one set.
// - A miss starts a hardware table walk that fills the TLB.
// - A write to the invalidate-all register clears the main TLB in one step.
// - A write to the invalidate-one register clears entries matching it.
// - Lockdown register selects where the next walk result is written.
// - Each region belongs to one of 16 domains set in the domain register.
// - Domain field selects check permissions, allow always or abort always.
// - Allow-always and abort-always domains ignore the entry permissions.
// - Permitted off-chip access drives the translated physical address.
// - Permitted cacheable access is left to cache or local fast memory.
// - A denied access answers the core with an abort.
// - After reset translation is off, flat mapped, uncached, unbuffered.
// - Addresses below 32MB get the remap id times 32MB added; id resets 0.
// - With translation off, no process remapping is applied.
// - With preserve set, walks fill lockdown entry victim, which increments.
// - Invalidate-all spares lockdown entries; invalidate-one clears both.
package mtlb_pkg;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TTB = 8'h04;
	localparam logic [7:0] REG_DOM = 8'h08;
	localparam logic [7:0] REG_PID = 8'h0C;
	localparam logic [7:0] REG_LOCK = 8'h10;
	localparam logic [7:0] REG_INV_ALL = 8'h14;
	localparam logic [7:0] REG_INV_ONE = 8'h18;
	localparam logic [7:0] REG_FSR = 8'h1C;
	localparam logic [7:0] REG_FAR = 8'h20;
	localparam int CTL_M = 0;
	localparam int CTL_S = 1;
	localparam int CTL_R = 2;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	localparam logic [31:0] TTB_MASK = 32'hFFFF_C000;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DOM_RST = 32'h0000_0000;
	localparam logic [6:0] PID_RST = 7'h00;
	localparam int PID_LSB = 25;
	localparam int LOCK_P = 0;
	localparam int LOCK_VIC = 26;
	localparam logic [1:0] PID_FETCHES = 2'h2;
	localparam int NSET = 32;
	localparam int NENT = 72;
	localparam int NCAND = 10;
	localparam int LOCK_BASE = 64;
	localparam logic [1:0] DESC_FAULT = 2'h0;
	localparam logic [1:0] L1_SECT = 2'h2;
	localparam logic [1:0] L1_FINE = 2'h3;
	localparam logic [1:0] L2_LARGE = 2'h1;
	localparam logic [1:0] L2_SMALL = 2'h2;
	localparam logic [3:0] FLT_TR_SEC = 4'h5;
	localparam logic [3:0] FLT_TR_PG = 4'h7;
	localparam logic [3:0] FLT_DOM_SEC = 4'h9;
	localparam logic [3:0] FLT_DOM_PG = 4'hB;
	localparam logic [3:0] FLT_PRM_SEC = 4'hD;
	localparam logic [3:0] FLT_PRM_PG = 4'hF;
	localparam logic [1:0] DAC_CLIENT = 2'h1;
	localparam logic [1:0] DAC_MGR = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SZ_SEC, SZ_LARGE, SZ_SMALL, SZ_TINY} mtlb_size_e;

	// Mask over address bits 31:10 that a mapping of this size keeps
	function automatic logic [21:0] page_mask(input mtlb_size_e sz);
		case (sz)
			SZ_SEC: page_mask = 22'h3FFC00;
			SZ_LARGE: page_mask = 22'h3FFFC0;
			SZ_SMALL: page_mask = 22'h3FFFFC;
			default: page_mask = 22'h3FFFFF;
		endcase
	endfunction : page_mask

	function automatic logic tag_hit(input logic [21:0] tag,
		input mtlb_size_e sz, input logic [31:0] addr);
		tag_hit = ((tag ^ addr[31:10]) & page_mask(sz)) == 22'h000000;
	endfunction : tag_hit
endpackage : mtlb_pkg

// file: hw/mtlb_top.sv
// TLB translation unit: remapper, unified TLB, walker, register slave
`timescale 1ns/10ps
module mtlb_top (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register bus, AXI4-Lite
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Core access request
	input wire logic core_valid,
	output logic core_ready,
	input wire logic [31:0] core_addr,
	input wire logic core_write,
	input wire logic core_priv,
	input wire logic core_fetch,
	// Core access answer
	output logic resp_valid,
	output logic resp_abort,
	output logic [31:0] resp_paddr,
	output logic resp_offchip,
	output logic resp_cacheable,
	output logic resp_bufferable,
	// Table walk read port
	output logic walk_valid,
	output logic [31:0] walk_addr,
	input wire logic walk_ack,
	input wire logic [31:0] walk_rdata
);
	localparam int NENT = mtlb_pkg::NENT;
	localparam int NCAND = mtlb_pkg::NCAND;
	localparam int LBASE = mtlb_pkg::LOCK_BASE;
	typedef enum logic [1:0] {ST_IDLE, ST_L1, ST_L2} mtlb_state_e;

	function automatic logic mapped(input logic [7:0] a, input logic wr);
		if (a == mtlb_pkg::REG_INV_ALL || a == mtlb_pkg::REG_INV_ONE) begin
			mapped = wr;
		end else if (a == mtlb_pkg::REG_CTRL || a == mtlb_pkg::REG_TTB ||
			a == mtlb_pkg::REG_DOM || a == mtlb_pkg::REG_PID ||
			a == mtlb_pkg::REG_LOCK || a == mtlb_pkg::REG_FSR ||
			a == mtlb_pkg::REG_FAR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	endfunction : mapped

	function automatic logic ap_ok(input logic [1:0] ap, input logic priv,
		input logic wr, input logic s, input logic r);
		case (ap)
			2'h0: ap_ok = !wr && ((s && priv) || (r && !s));
			2'h1: ap_ok = priv;
			2'h2: ap_ok = priv || !wr;
			default: ap_ok = 1'b1;
		endcase
	endfunction : ap_ok

	logic [31:0] ctrl_q, ttb_q, dom_q, far_q, rdata_q;
	logic [7:0] fsr_q;
	logic [6:0] pid_q, pid_act_q;
	logic [1:0] pid_cnt_q, bresp_q, rresp_q;
	logic pid_pend_q, lock_p_q, bvalid_q, rvalid_q;
	logic [2:0] victim_q;
	logic [31:0] rr_q;
	logic [NENT-1:0] vld_q;
	logic [21:0] tag_q [NENT];
	logic [21:0] pa_q [NENT];
	mtlb_pkg::mtlb_size_e sz_q [NENT];
	logic [3:0] edom_q [NENT];
	logic [7:0] ap_q [NENT];
	logic [1:0] cb_q [NENT];
	mtlb_state_e st_q;
	logic walk_valid_q, wfetch_q, flt_pend_q;
	logic [31:0] walk_addr_q, wmva_q;
	logic [3:0] wdom_q;
	logic resp_valid_q, resp_abort_q, resp_off_q, resp_c_q, resp_b_q;
	logic [31:0] resp_paddr_q;

	// Register bus decode
	logic aw_take, wr_ok, inv_all_w, inv_one_w, ar_take;
	assign aw_take = awvalid && wvalid && !bvalid_q;
	assign awready = aw_take;
	assign wready = aw_take;
	assign wr_ok = aw_take && wstrb == 4'hF && mapped(awaddr, 1'b1);
	assign inv_all_w = wr_ok && awaddr == mtlb_pkg::REG_INV_ALL;
	assign inv_one_w = wr_ok && awaddr == mtlb_pkg::REG_INV_ONE;
	assign ar_take = arvalid && !rvalid_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Address remap and lookup
	logic mmu_on;
	logic [31:0] mva_w;
	logic [4:0] set_w, wset_w;
	assign mmu_on = ctrl_q[mtlb_pkg::CTL_M];
	always_comb begin
		mva_w = core_addr;
		if (mmu_on && core_addr[31:mtlb_pkg::PID_LSB] == 7'h00) begin
			mva_w = {pid_act_q, core_addr[mtlb_pkg::PID_LSB-1:0]};
		end
	end
	assign set_w = mva_w[24:20];
	assign wset_w = wmva_q[24:20];

	logic [6:0] cidx [NCAND];
	logic [NCAND-1:0] chit;
	// Two main ways at this set plus every lockdown entry
	for (genvar k = 0; k < NCAND; k++) begin : g_cand
		if (k < 2) begin : g_main
			assign cidx[k] = 7'(k * mtlb_pkg::NSET) + {2'b00, set_w};
		end else begin : g_lock
			assign cidx[k] = 7'(LBASE + k - 2);
		end
		assign chit[k] = vld_q[cidx[k]] &&
			mtlb_pkg::tag_hit(tag_q[cidx[k]], sz_q[cidx[k]], mva_w);
	end

	logic [6:0] sel_w;
	logic hit_w;
	always_comb begin
		sel_w = cidx[0];
		for (int k = NCAND - 1; k >= 0; k--) begin
			if (chit[k]) begin
				sel_w = cidx[k];
			end
		end
	end
	assign hit_w = |chit;

	logic [7:0] e_ap;
	logic [3:0] e_dom;
	logic [1:0] ap_w, dac_w;
	logic pg_w, dom_flt, prm_flt, abort_w;
	logic [21:0] msk_w;
	logic [31:0] pa_w;
	assign e_ap = ap_q[sel_w];
	assign e_dom = edom_q[sel_w];
	assign pg_w = sz_q[sel_w] != mtlb_pkg::SZ_SEC;
	always_comb begin
		case (sz_q[sel_w])
			mtlb_pkg::SZ_LARGE: ap_w = e_ap[{mva_w[15:14], 1'b0} +: 2];
			mtlb_pkg::SZ_SMALL: ap_w = e_ap[{mva_w[11:10], 1'b0} +: 2];
			default: ap_w = e_ap[1:0];
		endcase
	end
	assign dac_w = dom_q[{e_dom, 1'b0} +: 2];
	// Reserved domain code aborts like no-access
	assign dom_flt = dac_w != mtlb_pkg::DAC_CLIENT && dac_w != mtlb_pkg::DAC_MGR;
	assign prm_flt = dac_w == mtlb_pkg::DAC_CLIENT && !ap_ok(ap_w, core_priv,
		core_write, ctrl_q[mtlb_pkg::CTL_S], ctrl_q[mtlb_pkg::CTL_R]);
	assign abort_w = mmu_on && (flt_pend_q || dom_flt || prm_flt);
	assign msk_w = mtlb_pkg::page_mask(sz_q[sel_w]);
	assign pa_w = {(pa_q[sel_w] & msk_w) | (mva_w[31:10] & ~msk_w), mva_w[9:0]};

	assign core_ready = core_valid && st_q == ST_IDLE &&
		(!mmu_on || hit_w || flt_pend_q);

	// Walk result decode
	logic fill_go, walk_flt;
	mtlb_pkg::mtlb_size_e fill_sz;
	logic [7:0] fill_ap;
	logic [3:0] fill_dom;
	logic [6:0] fill_idx;
	always_comb begin
		fill_go = 1'b0;
		fill_sz = mtlb_pkg::SZ_SEC;
		fill_ap = {4{walk_rdata[11:10]}};
		fill_dom = walk_rdata[8:5];
		if (walk_ack && st_q == ST_L1 && walk_rdata[1:0] == mtlb_pkg::L1_SECT) begin
			fill_go = 1'b1;
		end
		if (walk_ack && st_q == ST_L2 && walk_rdata[1:0] != mtlb_pkg::DESC_FAULT) begin
			fill_go = 1'b1;
			fill_dom = wdom_q;
			fill_ap = walk_rdata[11:4];
			case (walk_rdata[1:0])
				mtlb_pkg::L2_LARGE: fill_sz = mtlb_pkg::SZ_LARGE;
				mtlb_pkg::L2_SMALL: fill_sz = mtlb_pkg::SZ_SMALL;
				default: begin
					fill_sz = mtlb_pkg::SZ_TINY;
					fill_ap = {4{walk_rdata[5:4]}};
				end
			endcase
		end
	end
	assign walk_flt = walk_ack && st_q != ST_IDLE &&
		walk_rdata[1:0] == mtlb_pkg::DESC_FAULT;
	assign fill_idx = lock_p_q ? 7'(LBASE) + {4'h0, victim_q}
		: {1'b0, rr_q[wset_w], wset_w};

	// Table walker
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			walk_valid_q <= 1'b0;
			walk_addr_q <= 32'h0000_0000;
			wmva_q <= 32'h0000_0000;
			wdom_q <= 4'h0;
			wfetch_q <= 1'b0;
			flt_pend_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (core_ready) begin
						flt_pend_q <= 1'b0;
					end else if (core_valid && mmu_on && !flt_pend_q) begin
						st_q <= ST_L1;
						walk_valid_q <= 1'b1;
						walk_addr_q <= {ttb_q[31:14], mva_w[31:20], 2'b00};
						wmva_q <= mva_w;
						wfetch_q <= core_fetch;
					end
				end
				ST_L1: begin
					if (walk_ack) begin
						wdom_q <= walk_rdata[8:5];
						if (walk_rdata[0]) begin
							st_q <= ST_L2;
							walk_addr_q <= walk_rdata[1:0] == mtlb_pkg::L1_FINE ?
								{walk_rdata[31:12], wmva_q[19:10], 2'b00} :
								{walk_rdata[31:10], wmva_q[19:12], 2'b00};
						end else begin
							st_q <= ST_IDLE;
							walk_valid_q <= 1'b0;
							flt_pend_q <= walk_flt;
						end
					end
				end
				default: begin
					if (walk_ack) begin
						st_q <= ST_IDLE;
						walk_valid_q <= 1'b0;
						flt_pend_q <= walk_flt;
					end
				end
			endcase
		end
	end
	assign walk_valid = walk_valid_q;
	assign walk_addr = walk_addr_q;

	// Entry valid bits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vld_q <= '0;
		end else begin
			for (int i = 0; i < NENT; i++) begin
				if (inv_all_w && i < LBASE) begin
					vld_q[i] <= 1'b0;
				end
				// No remap on maintenance addresses
				if (inv_one_w && mtlb_pkg::tag_hit(tag_q[i], sz_q[i], wdata)) begin
					vld_q[i] <= 1'b0;
				end
			end
			if (fill_go) begin
				vld_q[fill_idx] <= 1'b1;
			end
		end
	end

	// Entry payload, gated by the valid bits so no reset needed
	always_ff @(posedge clk) begin
		if (fill_go) begin
			tag_q[fill_idx] <= wmva_q[31:10];
			pa_q[fill_idx] <= walk_rdata[31:10];
			sz_q[fill_idx] <= fill_sz;
			edom_q[fill_idx] <= fill_dom;
			ap_q[fill_idx] <= fill_ap;
			cb_q[fill_idx] <= walk_rdata[3:2];
		end
	end

	// Replacement pointers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rr_q <= 32'h0000_0000;
			victim_q <= 3'h0;
			lock_p_q <= 1'b0;
		end else begin
			if (fill_go && !lock_p_q) begin
				rr_q[wset_w] <= ~rr_q[wset_w];
			end
			if (wr_ok && awaddr == mtlb_pkg::REG_LOCK) begin
				lock_p_q <= wdata[mtlb_pkg::LOCK_P];
				victim_q <= wdata[mtlb_pkg::LOCK_VIC +: 3];
			end else if (fill_go && lock_p_q) begin
				victim_q <= victim_q + 3'h1;
			end
		end
	end

	// Process remap id, applied after two further fetches
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pid_q <= mtlb_pkg::PID_RST;
			pid_act_q <= mtlb_pkg::PID_RST;
			pid_pend_q <= 1'b0;
			pid_cnt_q <= 2'h0;
		end else if (wr_ok && awaddr == mtlb_pkg::REG_PID) begin
			pid_q <= wdata[31:mtlb_pkg::PID_LSB];
			pid_pend_q <= 1'b1;
			pid_cnt_q <= 2'h0;
		end else if (pid_pend_q && core_ready && core_fetch) begin
			if (pid_cnt_q == mtlb_pkg::PID_FETCHES - 2'h1) begin
				pid_act_q <= pid_q;
				pid_pend_q <= 1'b0;
			end else begin
				pid_cnt_q <= pid_cnt_q + 2'h1;
			end
		end
	end

	// Control registers and fault capture
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= mtlb_pkg::CTRL_RST;
			ttb_q <= 32'h0000_0000;
			dom_q <= mtlb_pkg::DOM_RST;
			fsr_q <= 8'h00;
			far_q <= 32'h0000_0000;
		end else begin
			if (wr_ok && awaddr == mtlb_pkg::REG_CTRL) begin
				ctrl_q <= wdata & mtlb_pkg::CTRL_MASK;
			end
			if (wr_ok && awaddr == mtlb_pkg::REG_TTB) begin
				ttb_q <= wdata & mtlb_pkg::TTB_MASK;
			end
			if (wr_ok && awaddr == mtlb_pkg::REG_DOM) begin
				dom_q <= wdata;
			end
			// Hardware capture wins over a software write in the same cycle
			if (walk_flt) begin
				fsr_q <= {st_q == ST_L1 ? 4'h0 : wdom_q,
					st_q == ST_L1 ? mtlb_pkg::FLT_TR_SEC : mtlb_pkg::FLT_TR_PG};
			end else if (core_ready && abort_w && !flt_pend_q) begin
				fsr_q <= {e_dom, dom_flt ?
					(pg_w ? mtlb_pkg::FLT_DOM_PG : mtlb_pkg::FLT_DOM_SEC) :
					(pg_w ? mtlb_pkg::FLT_PRM_PG : mtlb_pkg::FLT_PRM_SEC)};
			end else if (wr_ok && awaddr == mtlb_pkg::REG_FSR) begin
				fsr_q <= wdata[7:0];
			end
			if (walk_flt && !wfetch_q) begin
				far_q <= wmva_q;
			end else if (core_ready && abort_w && !flt_pend_q && !core_fetch) begin
				far_q <= mva_w;
			end else if (wr_ok && awaddr == mtlb_pkg::REG_FAR) begin
				far_q <= wdata;
			end
		end
	end

	// Core answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resp_valid_q <= 1'b0;
			resp_abort_q <= 1'b0;
			resp_paddr_q <= 32'h0000_0000;
			resp_off_q <= 1'b0;
			resp_c_q <= 1'b0;
			resp_b_q <= 1'b0;
		end else begin
			resp_valid_q <= core_ready;
			if (core_ready) begin
				resp_abort_q <= abort_w;
				resp_paddr_q <= mmu_on ? pa_w : core_addr;
				resp_c_q <= mmu_on && !abort_w && cb_q[sel_w][1];
				resp_b_q <= mmu_on && !abort_w && cb_q[sel_w][0];
				resp_off_q <= !abort_w && !(mmu_on && cb_q[sel_w][1]);
			end
		end
	end
	assign resp_valid = resp_valid_q;
	assign resp_abort = resp_abort_q;
	assign resp_paddr = resp_paddr_q;
	assign resp_offchip = resp_off_q;
	assign resp_cacheable = resp_c_q;
	assign resp_bufferable = resp_b_q;

	// Bus answers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= mtlb_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= mtlb_pkg::RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (aw_take) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? mtlb_pkg::RESP_OKAY : mtlb_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rresp_q <= mapped(araddr, 1'b0) ? mtlb_pkg::RESP_OKAY :
					mtlb_pkg::RESP_SLVERR;
				if (araddr == mtlb_pkg::REG_CTRL) begin
					rdata_q <= ctrl_q;
				end else if (araddr == mtlb_pkg::REG_TTB) begin
					rdata_q <= ttb_q;
				end else if (araddr == mtlb_pkg::REG_DOM) begin
					rdata_q <= dom_q;
				end else if (araddr == mtlb_pkg::REG_PID) begin
					rdata_q <= {pid_q, 25'h0000000};
				end else if (araddr == mtlb_pkg::REG_LOCK) begin
					rdata_q <= {3'h0, victim_q, 25'h0000000, lock_p_q};
				end else if (araddr == mtlb_pkg::REG_FSR) begin
					rdata_q <= {24'h000000, fsr_q};
				end else if (araddr == mtlb_pkg::REG_FAR) begin
					rdata_q <= far_q;
				end else begin
					rdata_q <= 32'h0000_0000;
				end
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Checks
	default clocking cb_chk @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_sec_walk;
		st_q == ST_L1 && walk_ack && walk_rdata[1:0] == mtlb_pkg::L1_SECT;
	endsequence
	sequence s_lock_fill;
		fill_go && lock_p_q && !(wr_ok && awaddr == mtlb_pkg::REG_LOCK);
	endsequence

	chk_off_flat: assert property (core_ready && !mmu_on |=>
		resp_valid && !resp_abort && resp_paddr == $past(core_addr)
		&& !resp_cacheable && !resp_bufferable)
		else $error("translation off did not pass address flat");
	chk_pid_hold: assert property (wr_ok && awaddr == mtlb_pkg::REG_PID
		|=> pid_act_q == $past(pid_act_q))
		else $error("remap id applied too early");
	chk_sec_fill: assert property (s_sec_walk |=> st_q == ST_IDLE
		&& vld_q[$past(fill_idx)])
		else $error("section walk did not fill the TLB");
	chk_victim_step: assert property (s_lock_fill |=>
		victim_q == $past(victim_q) + 3'h1)
		else $error("lockdown victim did not advance");
	chk_inv_keep: assert property (inv_all_w && !fill_go |=>
		vld_q[LBASE-1:0] == '0 && vld_q[NENT-1:LBASE] ==
		$past(vld_q[NENT-1:LBASE]))
		else $error("invalidate-all touched the wrong region");
	chk_miss_walk: assert property (st_q == ST_IDLE && core_valid &&
		mmu_on && !hit_w && !flt_pend_q |=> walk_valid && st_q == ST_L1)
		else $error("miss did not start a walk");
	chk_mgr_allow: assert property (core_ready && mmu_on && hit_w &&
		!flt_pend_q && dac_w == mtlb_pkg::DAC_MGR |=> !resp_abort)
		else $error("manager domain access aborted");
	chk_deny_abort: assert property (core_ready && mmu_on &&
		!flt_pend_q && dac_w == 2'h0 |=> resp_abort && !resp_offchip)
		else $error("no-access domain did not abort");
	chk_rr_turn: assert property (fill_go && !lock_p_q |=>
		rr_q[$past(wset_w)] != $past(rr_q[wset_w]))
		else $error("round-robin pointer did not turn");
endmodule : mtlb_top

// file: testbench/mtlb_mem.sv
// Table memory model answering the walker read port
`timescale 1ns/10ps
module mtlb_mem (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Walk read port
	input wire logic walk_valid,
	input wire logic [31:0] walk_addr,
	output logic walk_ack,
	output logic [31:0] walk_rdata
);
	logic [2:0] wait_q;
	logic [11:0] idx;
	assign idx = walk_addr[13:2];
	// Index bits pick every field; index bits 7:6 both set give a fault
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			walk_ack <= 1'b0;
			walk_rdata <= 32'h0;
			wait_q <= 3'h0;
		end else if (walk_valid && !walk_ack && wait_q == 3'h0) begin
			walk_ack <= 1'b1;
			walk_rdata <= {idx + 12'h001, 8'h00, idx[5], 1'b1, 1'b0,
				idx[3:0], 1'b0, idx[4], idx[6],
				idx[7:6] == 2'h3 ? 2'h0 : 2'h2};
			wait_q <= 3'($urandom % 5);
		end else begin
			// Released line inverts every cycle, so stale data alternates with its complement
			walk_ack <= 1'b0;
			walk_rdata <= ~walk_rdata;
			if (walk_valid && wait_q != 3'h0)
				wait_q <= wait_q - 3'h1;
		end
	end
endmodule : mtlb_mem

// file: testbench/testbench.sv
// Self-checking bench for the TLB translation unit
`timescale 1ns/10ps
module testbench;
	logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, core_valid, core_ready;
	logic core_write, core_priv, core_fetch, resp_valid, resp_abort;
	logic resp_offchip, resp_cacheable, resp_bufferable, walk_valid;
	logic walk_ack;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, core_addr, resp_paddr, walk_addr;
	logic [31:0] walk_rdata, dom_v, a;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [6:0] pid_now;
	logic mmu_on;
	logic [35:0] q[$];
	int fail_count, comparisons, walks, n0, i;
	mtlb_top i_dut (.clk, .nrst, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .core_valid,
		.core_ready, .core_addr, .core_write, .core_priv, .core_fetch,
		.resp_valid, .resp_abort, .resp_paddr, .resp_offchip,
		.resp_cacheable, .resp_bufferable, .walk_valid, .walk_addr,
		.walk_ack, .walk_rdata);
	mtlb_mem i_mem (.clk, .nrst, .walk_valid, .walk_addr, .walk_ack,
		.walk_rdata);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude
	task automatic guard(input int n);
		if (n >= 200) begin
			fail_count++;
			$display("BAD wait expected answer seen none");
			conclude();
		end
	endtask : guard
	task automatic chk(input string nm, input logic [33:0] e,
		input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_core(input logic [35:0] e, input logic [35:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD answer expected %h seen %h", e, g);
		end
	endtask : chk_core
	task automatic bwr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= ad;
		wdata <= d;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (awready === 1'b1) break;
		end
		guard(n);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (bvalid === 1'b1) break;
		end
		guard(n);
		bready <= 1'b0;
		chk("bresp", {32'h0, e}, {32'h0, bresp});
	endtask : bwr
	task automatic brd(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] e);
		int n;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= ad;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (arready === 1'b1) break;
		end
		guard(n);
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (rvalid === 1'b1) break;
		end
		guard(n);
		rready <= 1'b0;
		chk("read", {e, d}, {rresp, rdata});
	endtask : brd
	// Expected {abort, cacheable, bufferable, offchip, paddr} from the model
	function automatic logic [35:0] expect_of(input logic [31:0] va,
		input logic p);
		logic [31:0] m;
		logic [11:0] x;
		logic [1:0] c;
		if (!mmu_on) return {4'h1, va};
		m = (va[31:25] == 7'h00) ? {pid_now, va[24:0]} : va;
		x = m[31:20];
		c = dom_v[2 * x[3:0] +: 2];
		// A fault descriptor aborts whatever the domain says
		if (x[7:6] == 2'h3 || !c[0] || (c == 2'h1 && !x[5] && !p))
			return {4'h8, 32'h0};
		return {1'b0, x[4], x[6], !x[4], x + 12'h001, m[19:0]};
	endfunction : expect_of
	task automatic acc(input logic [31:0] va, input logic f,
		input logic p);
		int n;
		q.push_back(expect_of(va, p));
		@(posedge clk);
		core_valid <= 1'b1;
		core_addr <= va;
		core_fetch <= f;
		core_priv <= p;
		core_write <= 1'($urandom % 2);
		for (n = 0; n < 200; n++) begin
			@(posedge clk);
			if (core_ready === 1'b1) break;
		end
		guard(n);
		core_valid <= 1'b0;
	endtask : acc
	always @(posedge clk) begin
		if (walk_valid === 1'b1 && walk_ack === 1'b1)
			walks <= walks + 1;
		if (resp_valid === 1'b1) begin
			if (q.size() == 0)
				chk("spare answer", 34'h0, 34'h1);
			else
				chk_core(q.pop_front(), {resp_abort, resp_cacheable,
					resp_bufferable, resp_offchip,
					resp_abort ? 32'h0 : resp_paddr});
		end
	end
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready, core_valid} = 0;
		{core_write, core_priv, core_fetch, mmu_on} = 0;
		{awaddr, araddr, wdata, core_addr, dom_v} = 0;
		wstrb = 4'hF;
		pid_now = 7'h05;
		walks = 0;
		void'($urandom(9));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		brd(mtlb_pkg::REG_CTRL, mtlb_pkg::CTRL_RST, mtlb_pkg::RESP_OKAY);
		brd(mtlb_pkg::REG_PID, 32'h0, mtlb_pkg::RESP_OKAY);
		brd(8'h24, 32'h0, mtlb_pkg::RESP_SLVERR);
		brd(mtlb_pkg::REG_INV_ALL, 32'h0, mtlb_pkg::RESP_SLVERR);
		// Partial strobes are refused and leave the register alone
		wstrb <= 4'h3;
		bwr(mtlb_pkg::REG_TTB, 32'hFFFF_FFFF, mtlb_pkg::RESP_SLVERR);
		wstrb <= 4'hF;
		brd(mtlb_pkg::REG_TTB, 32'h0, mtlb_pkg::RESP_OKAY);
		bwr(mtlb_pkg::REG_PID, 32'h0A00_0000, mtlb_pkg::RESP_OKAY);
		for (i = 0; i < 4; i++)
			acc($urandom & 32'h01FF_FFFF, 1'b1, 1'b1);
		$display("test flat mapping done");
		dom_v = $urandom;
		bwr(mtlb_pkg::REG_DOM, dom_v, mtlb_pkg::RESP_OKAY);
		brd(mtlb_pkg::REG_DOM, dom_v, mtlb_pkg::RESP_OKAY);
		bwr(mtlb_pkg::REG_TTB, 32'h0000_4000, mtlb_pkg::RESP_OKAY);
		bwr(mtlb_pkg::REG_CTRL, 32'h1, mtlb_pkg::RESP_OKAY);
		mmu_on = 1'b1;
		// Second access to each non-faulting section is a back-to-back hit
		for (i = 0; i < 16; i++) begin
			a = $urandom;
			if (i[0]) a[31:25] = 7'h00;
			acc(a, 1'b0, 1'($urandom % 2));
			acc(a ^ 32'h000A_BCDE, 1'b0, 1'($urandom % 2));
		end
		$display("test translation done");
		bwr(mtlb_pkg::REG_PID, 32'h1400_0000, mtlb_pkg::RESP_OKAY);
		for (i = 0; i < 4; i++) begin
			pid_now = (i < 2) ? 7'h05 : 7'h0A;
			acc($urandom & 32'h01FF_FFFF, 1'b1, 1'b1);
		end
		brd(mtlb_pkg::REG_PID, 32'h1400_0000, mtlb_pkg::RESP_OKAY);
		$display("test remap switch done");
		a = 32'h4000_0000 | ($urandom & 32'h07FF_FFFF);
		acc(a, 1'b0, 1'b1);
		n0 = walks;
		acc(a, 1'b0, 1'b1);
		chk("walks", 34'(n0), 34'(walks));
		bwr(mtlb_pkg::REG_INV_ALL, 32'h0, mtlb_pkg::RESP_OKAY);
		acc(a, 1'b0, 1'b1);
		chk("walks", 34'(n0 + 1), 34'(walks));
		bwr(mtlb_pkg::REG_INV_ONE, a, mtlb_pkg::RESP_OKAY);
		acc(a, 1'b0, 1'b1);
		chk("walks", 34'(n0 + 2), 34'(walks));
		bwr(mtlb_pkg::REG_LOCK, 32'h0000_0001, mtlb_pkg::RESP_OKAY);
		acc(a ^ 32'h0100_0000, 1'b0, 1'b1);
		brd(mtlb_pkg::REG_LOCK, 32'h0400_0001, mtlb_pkg::RESP_OKAY);
		bwr(mtlb_pkg::REG_LOCK, 32'h0, mtlb_pkg::RESP_OKAY);
		bwr(mtlb_pkg::REG_INV_ALL, 32'h0, mtlb_pkg::RESP_OKAY);
		acc(a ^ 32'h0100_0000, 1'b0, 1'b1);
		chk("walks", 34'(n0 + 3), 34'(walks));
		bwr(mtlb_pkg::REG_INV_ONE, a ^ 32'h0100_0000,
			mtlb_pkg::RESP_OKAY);
		acc(a ^ 32'h0100_0000, 1'b0, 1'b1);
		chk("walks", 34'(n0 + 4), 34'(walks));
		acc(a | 32'h0C00_0000, 1'b0, 1'b1);
		brd(mtlb_pkg::REG_FSR, {28'h0000000, mtlb_pkg::FLT_TR_SEC},
			mtlb_pkg::RESP_OKAY);
		brd(mtlb_pkg::REG_FAR, a | 32'h0C00_0000, mtlb_pkg::RESP_OKAY);
		$display("test maintenance done");
		repeat (10) @(posedge clk);
		chk("queue", 34'h0, 34'(q.size()));
		conclude();
	end
endmodule : testbench
